// file: include/rpb_pkg.sv
// rpb_pkg: constants and carriers for the radio parameter bank
// Summary of operation
// - code 1C reads one byte, last packet strength, 06 to 36, read-only
// - larger signal-level values mean stronger reception; 36 is very strong
// - line-two-function code 16 selects 0 off, 1 binary programming, 2 RTS
// - RTS and binary programming stay off unless that value is written
// - stop-bit code 36: 0 gives one stop bit, 1 gives two
// - code 25 reads the upper serial number word; writes refused
// - code 26 reads the lower serial number word; read-only
// - serial number and idle time reads return two bytes, the other parameters one
// - sleep code 01 takes 0, 1, or 3 to 8 for 0.5 to 16 s cycles
// - sleep setting resets to 0, device stays awake
// - cyclic setting wakes the device each time its interval elapses
// - initializer seen while awake: synchronise, accept data once it ends
// - no initializer in the wake period: sleep again and keep cycling
// - idle time counts 100 ms units, default 64, then low power when sleep is cyclic (3 to 8)
package rpb_pkg;
   localparam logic [7:0] CODE_SLEEP = 8'h01;
   localparam logic [7:0] CODE_IDLE = 8'h02;
   localparam logic [7:0] CODE_LINE = 8'h16;
   localparam logic [7:0] CODE_RSSI = 8'h1C;
   localparam logic [7:0] CODE_SN_UP = 8'h25;
   localparam logic [7:0] CODE_SN_LO = 8'h26;
   localparam logic [7:0] CODE_STOP = 8'h36;
   localparam logic [7:0] SLEEP_RST = 8'h00;
   localparam logic [7:0] LINE_RST = 8'h00;
   localparam logic [7:0] STOP_RST = 8'h00;
   localparam logic [7:0] RSSI_RST = 8'h06;
   localparam logic [15:0] IDLE_RST = 16'h0064;
   localparam logic [15:0] IDLE_MIN = 16'h0010;
   localparam logic [7:0] RSSI_MIN = 8'h06;
   localparam logic [7:0] RSSI_MAX = 8'h36;
   localparam logic [7:0] SLEEP_OFF = 8'h00;
   localparam logic [7:0] SLEEP_PIN = 8'h01;
   localparam logic [7:0] SLEEP_CYC_FIRST = 8'h03;
   localparam logic [7:0] SLEEP_CYC_LAST = 8'h08;
   localparam logic [7:0] LINE_OFF = 8'h00;
   localparam logic [7:0] LINE_BINPROG = 8'h01;
   localparam logic [7:0] LINE_RTS = 8'h02;
   localparam logic [7:0] STOP_MAX = 8'h01;
   localparam logic [1:0] BYTES_ONE = 2'h1;
   localparam logic [1:0] BYTES_TWO = 2'h2;
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int WAKE_MS_BASE = 500;
   localparam logic [7:0] WAKE_TICKS_BASE = 8'(WAKE_MS_BASE / TICK_MS);
   localparam logic [7:0] LISTEN_TICKS_DEF = 8'h01;

   typedef struct packed {
      logic [7:0] code;
      logic write;
      logic [15:0] data;
   } rpb_cmd_s;

   typedef struct packed {
      logic [15:0] data;
      logic [1:0] bytes;
      logic error;
   } rpb_rsp_s;

   typedef enum logic [3:0] {
      PH_AWAKE = 4'b0001,
      PH_DOZE = 4'b0010,
      PH_LISTEN = 4'b0100,
      PH_SYNC = 4'b1000
   } rpb_state_e;
endpackage

// file: hw/rpb_tick_timer.sv
// rpb_tick_timer: down-counter of slow ticks with an expiry pulse
`timescale 1ns/10ps
module rpb_tick_timer #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [W-1:0] loadVal,
   input wire logic tickEn,
   output logic expired
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= loadVal;
      end else if (tickEn && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // registered so the consumer sees a clean one-cycle pulse
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= !load && tickEn && cnt_reg == W'(1);
      end
   end
endmodule

// file: hw/rpb_param_bank.sv
// rpb_param_bank: parameter bank with serial framing and sleep control
`timescale 1ns/10ps
module rpb_param_bank
   import rpb_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter logic [7:0] LISTEN_TICKS = LISTEN_TICKS_DEF,
   // serial number words: arbitrary values, set per unit
   parameter logic [15:0] SERIAL_UPPER = 16'h0A0B,
   parameter logic [15:0] SERIAL_LOWER = 16'h0C0D
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cmdValid,
   input wire rpb_cmd_s cmd,
   output logic rspValid,
   output rpb_rsp_s rsp,
   input wire logic rssiValid,
   input wire logic [7:0] rssiRaw,
   input wire logic activity,
   input wire logic sleepPin,
   input wire logic initDetect,
   input wire logic initDone,
   output logic rtsFlowEn,
   output logic binProgEn,
   output logic twoStopBits,
   output logic lowPower,
   output logic listening,
   output logic acceptData
);
   localparam int TW = $clog2(TICK_CYC + 1);

   logic [7:0] sleep_reg;
   logic [7:0] line_reg;
   logic [7:0] stop_reg;
   logic [7:0] rssi_reg;
   logic [15:0] idle_reg;
   rpb_state_e state_reg;
   rpb_state_e state_next;
   logic [TW-1:0] tick_reg;
   logic tickEn;
   logic isCyclic;
   logic [2:0] cycShift;
   logic [7:0] cycVal;
   logic cycLoad;
   logic cycExpired;
   logic idleLoad;
   logic idleExpired;
   logic wrHit;
   logic rdHit;

   assign wrHit = cmdValid && cmd.write;
   assign rdHit = cmdValid && !cmd.write;

   // slow 100 ms tick for every sleep-related count
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_reg <= '0;
      end else if (tick_reg == TW'(TICK_CYC - 1)) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 1'b1;
      end
   end

   assign tickEn = tick_reg == TW'(TICK_CYC - 1);

   // sleep setting: 2 and values above 8 are refused
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_reg <= SLEEP_RST;
      end else if (wrHit && cmd.code == CODE_SLEEP &&
                   cmd.data <= 16'(SLEEP_CYC_LAST) &&
                   cmd.data != 16'h0002) begin
         sleep_reg <= cmd.data[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         line_reg <= LINE_RST;
      end else if (wrHit && cmd.code == CODE_LINE &&
                   cmd.data <= 16'(LINE_RTS)) begin
         line_reg <= cmd.data[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stop_reg <= STOP_RST;
      end else if (wrHit && cmd.code == CODE_STOP &&
                   cmd.data <= 16'(STOP_MAX)) begin
         stop_reg <= cmd.data[7:0];
      end
   end

   // idle time below its floor would sleep almost at once, so it is refused
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_reg <= IDLE_RST;
      end else if (wrHit && cmd.code == CODE_IDLE &&
                   cmd.data >= IDLE_MIN) begin
         idle_reg <= cmd.data;
      end
   end

   // strength held clamped, so a reading never leaves the legal band
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rssi_reg <= RSSI_RST;
      end else if (rssiValid) begin
         if (rssiRaw < RSSI_MIN) begin
            rssi_reg <= RSSI_MIN;
         end else if (rssiRaw > RSSI_MAX) begin
            rssi_reg <= RSSI_MAX;
         end else begin
            rssi_reg <= rssiRaw;
         end
      end
   end

   // line-two roles only when the host selected them
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rtsFlowEn <= 1'b0;
         binProgEn <= 1'b0;
         twoStopBits <= 1'b0;
      end else begin
         rtsFlowEn <= line_reg == LINE_RTS;
         binProgEn <= line_reg == LINE_BINPROG;
         twoStopBits <= stop_reg == STOP_MAX;
      end
   end

   // answer one cycle after each command; unknown codes are errors
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rspValid <= 1'b0;
         rsp <= '0;
      end else begin
         rspValid <= cmdValid;
         if (cmdValid) begin
            rsp.data <= 16'h0000;
            rsp.bytes <= BYTES_ONE;
            rsp.error <= 1'b0;
            if (cmd.code == CODE_SLEEP) begin
               rsp.data <= 16'(sleep_reg);
               rsp.error <= cmd.write && (cmd.data > 16'(SLEEP_CYC_LAST) ||
                                          cmd.data == 16'h0002);
            end else if (cmd.code == CODE_IDLE) begin
               rsp.data <= idle_reg;
               rsp.bytes <= BYTES_TWO;
               rsp.error <= cmd.write && cmd.data < IDLE_MIN;
            end else if (cmd.code == CODE_LINE) begin
               rsp.data <= 16'(line_reg);
               rsp.error <= cmd.write && cmd.data > 16'(LINE_RTS);
            end else if (cmd.code == CODE_STOP) begin
               rsp.data <= 16'(stop_reg);
               rsp.error <= cmd.write && cmd.data > 16'(STOP_MAX);
            end else if (cmd.code == CODE_RSSI) begin
               rsp.data <= 16'(rssi_reg);
               rsp.error <= cmd.write;
            end else if (cmd.code == CODE_SN_UP) begin
               rsp.data <= SERIAL_UPPER;
               rsp.bytes <= BYTES_TWO;
               rsp.error <= cmd.write;
            end else if (cmd.code == CODE_SN_LO) begin
               rsp.data <= SERIAL_LOWER;
               rsp.bytes <= BYTES_TWO;
               rsp.error <= cmd.write;
            end else begin
               rsp.error <= 1'b1;
            end
         end
      end
   end

   assign isCyclic = sleep_reg >= SLEEP_CYC_FIRST &&
                     sleep_reg <= SLEEP_CYC_LAST;
   assign cycShift = 3'(sleep_reg - SLEEP_CYC_FIRST);

   // interval doubles per step: 0.5 s at 3 up to 16 s at 8
   always_comb begin
      cycLoad = 1'b0;
      cycVal = WAKE_TICKS_BASE << cycShift;
      if (state_reg != PH_DOZE && state_next == PH_DOZE) begin
         cycLoad = 1'b1;
      end else if (state_reg == PH_DOZE && state_next == PH_LISTEN) begin
         cycLoad = 1'b1;
         cycVal = LISTEN_TICKS;
      end else if (state_reg == PH_LISTEN && state_next == PH_DOZE) begin
         cycLoad = 1'b1;
      end
   end

   // held in reload while not awake, so counting restarts on each wake
   assign idleLoad = state_reg != PH_AWAKE || activity ||
                     (wrHit && cmd.code == CODE_IDLE);

   rpb_tick_timer #(
      .W(8)
   ) u_cycle_timer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .load(cycLoad),
      .loadVal(cycVal),
      .tickEn(tickEn),
      .expired(cycExpired)
   );

   rpb_tick_timer #(
      .W(16)
   ) u_idle_timer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .load(idleLoad),
      .loadVal(idle_reg),
      .tickEn(tickEn),
      .expired(idleExpired)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PH_AWAKE: begin
            if (sleep_reg == SLEEP_PIN && sleepPin) begin
               state_next = PH_DOZE;
            end else if (isCyclic && idleExpired && !activity) begin
               state_next = PH_DOZE;
            end
         end
         PH_DOZE: begin
            if (sleep_reg == SLEEP_OFF) begin
               state_next = PH_AWAKE;
            end else if (sleep_reg == SLEEP_PIN) begin
               if (!sleepPin) begin
                  state_next = PH_AWAKE;
               end
            end else if (!isCyclic) begin
               state_next = PH_AWAKE;
            end else if (cycExpired) begin
               state_next = PH_LISTEN;
            end
         end
         PH_LISTEN: begin
            if (!isCyclic) begin
               state_next = PH_AWAKE;
            end else if (initDetect) begin
               state_next = PH_SYNC;
            end else if (cycExpired) begin
               state_next = PH_DOZE;
            end
         end
         PH_SYNC: begin
            if (initDone || sleep_reg == SLEEP_OFF) begin
               state_next = PH_AWAKE;
            end
         end
         default: begin
            state_next = PH_AWAKE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= PH_AWAKE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign lowPower = state_reg == PH_DOZE;
   assign listening = state_reg == PH_LISTEN;
   assign acceptData = state_reg == PH_AWAKE;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   rsp_timing_a: assert property (cmdValid |=> rspValid)
      else $error("command not answered next cycle");
   rssi_range_a: assert property (
      rdHit && cmd.code == CODE_RSSI |=> rsp.data >= 16'(RSSI_MIN) &&
      rsp.data <= 16'(RSSI_MAX) && rsp.bytes == BYTES_ONE)
      else $error("signal level outside legal band");
   rssi_track_a: assert property (
      rssiValid && rssiRaw >= RSSI_MIN && rssiRaw <= RSSI_MAX ##1
      !rssiValid ##1 rdHit && cmd.code == CODE_RSSI |=>
      rsp.data == 16'($past(rssiRaw, 3)))
      else $error("signal level readout does not follow packet");
   line_gate_a: assert property (
      wrHit && cmd.code == CODE_LINE && cmd.data == 16'(LINE_RTS)
      |=> ##1 rtsFlowEn && !binProgEn)
      else $error("RTS role not enabled by its setting");
   line_off_a: assert property (
      line_reg == LINE_OFF |=> !rtsFlowEn && !binProgEn)
      else $error("line-two role active while disabled");
   stop_bits_a: assert property (
      wrHit && cmd.code == CODE_STOP && cmd.data == 16'h0001
      |=> ##1 twoStopBits)
      else $error("two stop bits not selected");
   sn_upper_a: assert property (
      cmdValid && cmd.code == CODE_SN_UP |=> rsp.data == SERIAL_UPPER &&
      rsp.bytes == BYTES_TWO && rsp.error == $past(cmd.write))
      else $error("upper serial word answer wrong");
   sn_lower_a: assert property (
      rdHit && cmd.code == CODE_SN_LO |=> rsp.data == SERIAL_LOWER &&
      rsp.bytes == BYTES_TWO && !rsp.error)
      else $error("lower serial word answer wrong");
   one_byte_a: assert property (
      rdHit && (cmd.code == CODE_RSSI || cmd.code == CODE_LINE ||
      cmd.code == CODE_STOP || cmd.code == CODE_SLEEP)
      |=> rsp.bytes == BYTES_ONE)
      else $error("one-byte parameter gave wrong length");
   bad_sleep_a: assert property (
      wrHit && cmd.code == CODE_SLEEP && cmd.data == 16'h0002
      |=> rsp.error && $stable(sleep_reg))
      else $error("sleep value 2 was accepted");
   sleep_off_a: assert property (
      sleep_reg == SLEEP_OFF && state_reg != PH_AWAKE |=> acceptData)
      else $error("disabled sleep did not wake device");
   cyc_wake_a: assert property (
      lowPower && isCyclic && cycExpired |=> listening)
      else $error("cyclic interval elapsed without waking");
   sync_accept_a: assert property (
      listening && isCyclic && initDetect ##1 initDone |=> acceptData)
      else $error("data not accepted after initializer");
   listen_fail_a: assert property (
      listening && isCyclic && !initDetect && cycExpired |=> lowPower)
      else $error("device stayed awake without initializer");
   idle_sleep_a: assert property (
      acceptData && isCyclic && idleExpired && !activity |=> lowPower)
      else $error("idle time elapsed without sleeping");
   pin_sleep_a: assert property (
      acceptData && sleep_reg == SLEEP_PIN && sleepPin |=> lowPower)
      else $error("pin sleep request ignored");

   cyc_cycle_c: cover property (lowPower ##1 listening ##[1:20] lowPower);
   sync_path_c: cover property (listening ##1 state_reg == PH_SYNC
                                ##[1:20] acceptData);
   sn_read_c: cover property (rdHit && cmd.code == CODE_SN_UP ##1
                              rdHit && cmd.code == CODE_SN_LO);
   sleep_off_c: cover property (lowPower && sleep_reg == SLEEP_OFF
                                ##1 acceptData);
endmodule

// file: test/rpb_host_model.sv
// rpb_host_model: host side that issues parameter commands to the bank
`timescale 1ns/10ps
module rpb_host_model
   import rpb_pkg::*;
(
   input wire logic core_clk,
   output logic cmdValid,
   output rpb_cmd_s cmd,
   input wire logic rspValid,
   input wire rpb_rsp_s rsp
);
   initial begin
      cmdValid = 1'b0;
      cmd = '0;
   end

   // gap idles the host first, so slow and close requests both occur
   task automatic issue(input logic [7:0] code, input logic wr,
                        input logic [15:0] d, input int gap,
                        output rpb_rsp_s r, output logic seen);
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      #1;
      cmdValid = 1'b1;
      cmd = '{code: code, write: wr, data: d};
      @(posedge core_clk);
      #1;
      cmdValid = 1'b0;
      // released command lines show junk, never the old command
      cmd = ~cmd;
      seen = rspValid;
      r = rsp;
   endtask
endmodule

// file: test/test_radio_param_bank_sleep_serial.sv
// test_radio_param_bank_sleep_serial: self-checking bench for the bank
`timescale 1ns/10ps
module test_radio_param_bank_sleep_serial;
   import rpb_pkg::*;
   typedef struct packed {
      logic [7:0] code;
      logic write;
      logic [15:0] data;
      logic [15:0] expData;
      logic [1:0] expBytes;
      logic expErr;
   } rpb_row_s;
   localparam int TICK = 10;
   localparam logic [15:0] SN_UP = 16'h1357;
   localparam logic [15:0] SN_LO = 16'h2468;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmdValid;
   rpb_cmd_s cmd;
   logic rspValid;
   rpb_rsp_s rsp;
   logic rssiValid = 1'b0;
   logic [7:0] rssiRaw = 8'h00;
   logic activity = 1'b0;
   logic sleepPin = 1'b0;
   logic initDetect = 1'b0;
   logic initDone = 1'b0;
   logic rtsFlowEn, binProgEn, twoStopBits, lowPower, listening, acceptData;
   int miscompares = 0;
   int numChecks = 0;
   rpb_rsp_s r;
   int n;
   int t;
   logic [7:0] raws [5] = '{8'h02, 8'h20, 8'h50, 8'h36, 8'h06};
   logic [7:0] clamped [5] = '{8'h06, 8'h20, 8'h36, 8'h36, 8'h06};
   rpb_row_s rows [24] = '{
      '{CODE_SLEEP, 1'b0, 16'h0, 16'h0, BYTES_ONE, 1'b0},
      '{CODE_LINE, 1'b0, 16'h0, 16'h0, BYTES_ONE, 1'b0},
      '{CODE_STOP, 1'b0, 16'h0, 16'h0, BYTES_ONE, 1'b0},
      '{CODE_RSSI, 1'b0, 16'h0, 16'h6, BYTES_ONE, 1'b0},
      '{CODE_SN_UP, 1'b0, 16'h0, SN_UP, BYTES_TWO, 1'b0},
      '{CODE_SN_LO, 1'b0, 16'h0, SN_LO, BYTES_TWO, 1'b0},
      '{CODE_IDLE, 1'b0, 16'h0, 16'h64, BYTES_TWO, 1'b0},
      '{CODE_STOP, 1'b1, 16'h1, 16'h0, BYTES_ONE, 1'b0},
      '{CODE_STOP, 1'b1, 16'h2, 16'h1, BYTES_ONE, 1'b1},
      '{CODE_STOP, 1'b0, 16'h0, 16'h1, BYTES_ONE, 1'b0},
      '{CODE_STOP, 1'b1, 16'h0, 16'h1, BYTES_ONE, 1'b0},
      '{CODE_LINE, 1'b1, 16'h3, 16'h0, BYTES_ONE, 1'b1},
      '{CODE_SLEEP, 1'b1, 16'h2, 16'h0, BYTES_ONE, 1'b1},
      '{CODE_SLEEP, 1'b1, 16'h9, 16'h0, BYTES_ONE, 1'b1},
      '{CODE_SLEEP, 1'b1, 16'h1, 16'h0, BYTES_ONE, 1'b0},
      '{CODE_SLEEP, 1'b0, 16'h0, 16'h1, BYTES_ONE, 1'b0},
      '{CODE_SLEEP, 1'b1, 16'h0, 16'h1, BYTES_ONE, 1'b0},
      '{CODE_SN_UP, 1'b1, 16'h1234, SN_UP, BYTES_TWO, 1'b1},
      '{CODE_SN_LO, 1'b1, 16'h1234, SN_LO, BYTES_TWO, 1'b1},
      '{CODE_RSSI, 1'b1, 16'h20, 16'h6, BYTES_ONE, 1'b1},
      '{CODE_IDLE, 1'b1, 16'hF, 16'h64, BYTES_TWO, 1'b1},
      '{CODE_IDLE, 1'b1, 16'h10, 16'h64, BYTES_TWO, 1'b0},
      '{CODE_IDLE, 1'b0, 16'h0, 16'h10, BYTES_TWO, 1'b0},
      '{8'h7F, 1'b0, 16'h0, 16'h0, BYTES_ONE, 1'b1}};

   always #5 core_clk = ~core_clk;

   rpb_host_model i_host (
      .core_clk(core_clk),
      .cmdValid(cmdValid),
      .cmd(cmd),
      .rspValid(rspValid),
      .rsp(rsp)
   );

   rpb_param_bank #(.TICK_CYC(TICK), .SERIAL_UPPER(SN_UP),
                    .SERIAL_LOWER(SN_LO)) i_dut (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .cmdValid(cmdValid),
      .cmd(cmd),
      .rspValid(rspValid),
      .rsp(rsp),
      .rssiValid(rssiValid),
      .rssiRaw(rssiRaw),
      .activity(activity),
      .sleepPin(sleepPin),
      .initDetect(initDetect),
      .initDone(initDone),
      .rtsFlowEn(rtsFlowEn),
      .binProgEn(binProgEn),
      .twoStopBits(twoStopBits),
      .lowPower(lowPower),
      .listening(listening),
      .acceptData(acceptData)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic finalReport();
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic doCmd(input logic [7:0] code, input logic wr,
                        input logic [15:0] d, input int gap,
                        output rpb_rsp_s rr);
      logic seen;
      i_host.issue(code, wr, d, gap, rr, seen);
      check(16'(seen), 16'h0001, "answer strobe");
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return lowPower;
         default: return listening;
      endcase
   endfunction

   // bounded wait; running out counts as a miscompare
   task automatic waitSig(input int w, input logic lvl, input int lim,
                          output int cnt);
      cnt = 0;
      while (pick(w) !== lvl && cnt < lim) begin
         step(1);
         cnt++;
      end
      if (cnt >= lim) check(16'h0, 16'h1, "wait limit");
   endtask

   initial begin
      #300000;
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      finalReport();
   end

   initial begin
      step(3);
      check({lowPower, listening, acceptData, rspValid}, 16'h2, "rst");
      step(2);
      arst_n = 1'b1;
      check({rtsFlowEn, binProgEn, twoStopBits}, 16'h0, "reset outs");
      foreach (rows[i]) begin
         doCmd(rows[i].code, rows[i].write, rows[i].data, i % 3, r);
         check(r.data, rows[i].expData, "data");
         check(16'(r.bytes), 16'(rows[i].expBytes), "bytes");
         check(16'(r.error), 16'(rows[i].expErr), "error");
      end
      $display("test table done");
      for (int v = 0; v < 3; v++) begin
         doCmd(CODE_LINE, 1'b1, 16'(v), 0, r);
         step(1);
         check(16'(rtsFlowEn), 16'(v == 2), "rts enable");
         check(16'(binProgEn), 16'(v == 1), "prog enable");
      end
      for (int v = 1; v >= 0; v--) begin
         doCmd(CODE_STOP, 1'b1, 16'(v), 0, r);
         step(1);
         check(16'(twoStopBits), 16'(v), "stop bits");
      end
      $display("test line and stop done");
      foreach (raws[i]) begin
         step(1);
         rssiValid = 1'b1;
         rssiRaw = raws[i];
         step(1);
         rssiValid = 1'b0;
         rssiRaw = ~raws[i];
         doCmd(CODE_RSSI, 1'b0, 16'h0, 0, r);
         check(r.data, 16'(clamped[i]), "signal level");
      end
      $display("test signal level done");
      doCmd(CODE_SLEEP, 1'b1, 16'h1, 0, r);
      sleepPin = 1'b1;
      step(3);
      check(16'(lowPower), 16'h1, "pin sleep");
      sleepPin = 1'b0;
      step(3);
      check(16'(lowPower), 16'h0, "pin wake");
      sleepPin = 1'b1;
      step(3);
      check(16'(lowPower), 16'h1, "pin sleep again");
      // disabling while asleep must wake even with the pin still high
      doCmd(CODE_SLEEP, 1'b1, 16'h0, 0, r);
      step(3);
      check(16'(lowPower), 16'h0, "pin ignored");
      sleepPin = 1'b0;
      $display("test pin sleep done");
      for (int s = 3; s <= 8; s++) begin
         t = (5 << (s - 3)) * TICK;
         doCmd(CODE_IDLE, 1'b1, 16'h0010, 0, r);
         doCmd(CODE_SLEEP, 1'b1, 16'(s), 0, r);
         activity = 1'b1;
         step(1);
         activity = 1'b0;
         waitSig(0, 1'b1, 400, n);
         check(16'(n >= 140 && n <= 190), 16'h1, "idle span");
         waitSig(1, 1'b1, t + 40, n);
         check(16'(n + 12 >= t && n <= t + 12), 16'h1, "wake span");
         if (s == 3) begin
            waitSig(1, 1'b0, 40, n);
            check(16'(lowPower), 16'h1, "back asleep");
            waitSig(1, 1'b1, t + 40, n);
            check(16'(n + 12 >= t && n <= t + 12), 16'h1, "recycle");
         end
         initDetect = 1'b1;
         step(1);
         initDetect = 1'b0;
         check({lowPower, listening, acceptData}, 16'h0, "sync");
         initDone = 1'b1;
         step(1);
         initDone = 1'b0;
         check(16'(acceptData), 16'h1, "accepting");
         doCmd(CODE_SLEEP, 1'b1, 16'h0, 0, r);
         step(1);
         check({lowPower, acceptData}, 16'h1, "awake again");
      end
      $display("test cyclic sleep done");
      doCmd(CODE_STOP, 1'b1, 16'h1, 0, r);
      doCmd(CODE_LINE, 1'b1, 16'h2, 0, r);
      step(1);
      arst_n = 1'b0;
      step(2);
      check({rtsFlowEn, twoStopBits, rspValid}, 16'h0, "mid reset");
      arst_n = 1'b1;
      doCmd(CODE_STOP, 1'b0, 16'h0, 0, r);
      check(r.data, 16'h0, "stop after reset");
      doCmd(CODE_SLEEP, 1'b0, 16'h0, 0, r);
      check(r.data, 16'h0, "sleep after reset");
      $display("test mid reset done");
      finalReport();
   end
endmodule
